// ---- core/byte_to_word_bus_adapter.sv ----
// control logic joining a 16-bit controller to an 8-bit processor bus
`timescale 1ns/1ps
`default_nettype none
`include "adapter_map.svh"
module byte_to_word_bus_adapter
  import adapter_pkg::*;
#(
  parameter int unsigned FIFO_DEPTH = `FIFO_DEPTH
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic address_strobe_n,
  input wire logic data_strobe_n_in,
  output logic data_strobe_n_out,
  output logic data_strobe_oe_n,
  input wire logic rw_in,
  output logic rw_out,
  output logic rw_oe_n,
  input wire logic bus_request_n,
  input wire logic grant_chain_in_n,
  input wire logic grant_chain_out_n,
  input wire logic command_data,
  input wire logic memory_ack,
  input wire logic chip_select_n,
  input wire logic cpu_rd_n,
  input wire logic cpu_wr_n,
  input wire logic sys_a0,
  input wire logic [`BYTE_W-1:0] sys_data_in,
  output logic [`BYTE_W-1:0] sys_data_out,
  output logic sys_data_oe_n,
  output logic sys_rd_n,
  output logic byte_select_lsb,
  output logic byte_select_oe_n,
  output logic ctrl_hold,
  input wire logic [`WORD_W-1:0] ctrl_data_in,
  output logic [`WORD_W-1:0] ctrl_data_out,
  output logic ctrl_data_oe_n,
  input wire logic receive_buffer_enable_n,
  output logic xcvr_to_ctrl,
  output logic port_output_enable_n,
  output logic latch_clock,
  output logic [`WORD_W-1:0] word_data,
  output logic word_valid,
  input wire logic word_ready
);
  state_t state_q;
  state_t state_d;
  logic master;
  logic slave_sel;
  logic start_master;
  logic slave_latch_go;
  logic slave_strobe_go;
  logic [`BYTE_W-1:0] latch_q;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [`WORD_W-1:0] fifo_out_data;
  logic push;

  // controller owns the bus once granted and not passing the grant on
  assign master = ~bus_request_n & ~grant_chain_in_n & grant_chain_out_n; // [R08]
  assign slave_sel = ~chip_select_n & ~master; // [R16]
  // a direction of write while master is only an address latch update
  assign start_master = master & ~address_strobe_n & ~data_strobe_n_in
                        & (rw_in == `DIR_READ) & ~memory_ack & fifo_in_ready; // [R01] [R02] [R03]
  // command accesses are byte wide and strobe at once
  assign slave_latch_go = slave_sel & ~cpu_wr_n & ~command_data
                          & (sys_a0 == `LATCHED_A0) & ~memory_ack; // [R01] [R13] [R18]
  assign slave_strobe_go = slave_sel & (~cpu_wr_n | ~cpu_rd_n) & ~memory_ack; // [R01] [R04]
  assign push = (state_q == ST_M_HI_WAIT) & memory_ack;

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (start_master) begin
          state_d = ST_M_LO_ISSUE;
        end else if (slave_latch_go) begin
          state_d = ST_SL_LATCH;
        end else if (slave_strobe_go) begin
          state_d = ST_SL_STROBE;
        end
      end
      ST_SL_LATCH: begin
        if (cpu_wr_n | chip_select_n) begin
          state_d = ST_IDLE;
        end
      end
      ST_SL_STROBE: begin
        if ((cpu_wr_n & cpu_rd_n) | chip_select_n) begin
          state_d = ST_IDLE;
        end
      end
      ST_M_LO_ISSUE: begin
        state_d = ST_M_LO_WAIT;
      end
      ST_M_LO_WAIT: begin
        if (memory_ack) begin
          state_d = ST_M_HI_ISSUE;
        end
      end
      ST_M_HI_ISSUE: begin
        // let the first acknowledge drop before the second read
        if (!memory_ack) begin
          state_d = ST_M_HI_WAIT;
        end
      end
      ST_M_HI_WAIT: begin
        if (memory_ack) begin
          state_d = ST_M_DONE;
        end
      end
      ST_M_DONE: begin
        if (data_strobe_n_in | address_strobe_n) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_q <= ST_IDLE; // [R19]
    end else begin
      state_q <= state_d;
    end
  end

  // hold is the top state bit: the four master states before ST_M_DONE stall the controller
  assign ctrl_hold = state_q[`HOLD_BIT]; // [R06] [R09]

  // system side read strobe and byte select while master
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sys_rd_n <= `STROBE_IDLE;
      byte_select_lsb <= 1'b0;
      byte_select_oe_n <= 1'b1;
    end else begin
      sys_rd_n <= ~((state_d == ST_M_LO_ISSUE) | (state_d == ST_M_LO_WAIT)
                    | (state_d == ST_M_HI_WAIT)); // [R03] [R05]
      byte_select_lsb <= (state_d == ST_M_HI_ISSUE) | (state_d == ST_M_HI_WAIT); // [R05]
      byte_select_oe_n <= ~master; // [R17]
    end
  end

  // controller data strobe and direction while slave
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      data_strobe_n_out <= `STROBE_IDLE;
      data_strobe_oe_n <= 1'b1;
      rw_out <= `DIR_READ;
      rw_oe_n <= 1'b1;
    end else begin
      // driven whenever not master, inactive outside ST_SL_STROBE, so no floating glitches
      data_strobe_oe_n <= master;
      rw_oe_n <= master;
      // only the strobing state pulses; the latch-only write stays quiet
      data_strobe_n_out <= ~(state_d == ST_SL_STROBE); // [R04] [R14]
      if (state_q == ST_IDLE && state_d == ST_SL_STROBE) begin
        rw_out <= cpu_wr_n; // [R04] [R07]
      end
    end
  end

  // byte latch and its single clock strobe
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      latch_q <= '0;
      latch_clock <= 1'b0;
    end else begin
      latch_clock <= 1'b0;
      if ((state_q == ST_IDLE && state_d == ST_SL_LATCH)
          || (state_q == ST_M_LO_WAIT && memory_ack)) begin
        latch_q <= sys_data_in;
        latch_clock <= 1'b1; // [R10]
      end
    end
  end

  // word presented to the controller on the strobing access
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ctrl_data_out <= '0;
      ctrl_data_oe_n <= 1'b1;
    end else begin
      if (state_q == ST_IDLE && state_d == ST_SL_STROBE) begin
        if (command_data) begin
          ctrl_data_out <= {{`BYTE_W{1'b0}}, sys_data_in};
        end else begin
          ctrl_data_out <= {latch_q, sys_data_in}; // [R13]
        end
      end
      ctrl_data_oe_n <= ~((state_d == ST_SL_STROBE) & ~cpu_wr_n);
    end
  end

  // slave read data back onto the narrow bus, byte chosen by system a0
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sys_data_out <= '0;
      sys_data_oe_n <= 1'b1;
      port_output_enable_n <= 1'b1;
      xcvr_to_ctrl <= 1'b0;
    end else begin
      sys_data_out <= sys_a0 ? ctrl_data_in[`WORD_W-1:`BYTE_W]
                             : ctrl_data_in[`BYTE_W-1:0];
      sys_data_oe_n <= ~((state_d == ST_SL_STROBE) & ~cpu_rd_n);
      port_output_enable_n <= ~((state_d == ST_SL_STROBE) & ~cpu_rd_n
                                & (sys_a0 == `LATCHED_A0)); // [R12]
      xcvr_to_ctrl <= ~receive_buffer_enable_n; // [R11] [R12]
    end
  end

  // assembled master-read words queue toward the controller
  word_fifo #(
    .WIDTH(`WORD_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clock(clock),
    .resetn(resetn),
    .in_valid(push),
    .in_ready(fifo_in_ready),
    .in_data({sys_data_in, latch_q}),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  assign fifo_out_ready = ~word_valid | word_ready;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      word_valid <= 1'b0;
      word_data <= '0;
    end else if (fifo_out_ready) begin
      word_valid <= fifo_out_valid;
      if (fifo_out_valid) begin
        word_data <= fifo_out_data;
      end
    end
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);

  a_idle_ack_gate: assert property (
    state_q == ST_IDLE && memory_ack |=> state_q == ST_IDLE) // [R01]
    else $error("cycle started while memory acknowledge active");
  a_no_addr_write: assert property (
    state_q == ST_IDLE && rw_in != `DIR_READ |=> !ctrl_hold) // [R02]
    else $error("sequence started on address latch update");
  a_master_read_lo: assert property (
    state_q == ST_M_LO_ISSUE |-> !sys_rd_n && !byte_select_lsb ##1 !sys_rd_n) // [R03]
    else $error("low byte read strobe missing");
  a_master_read_hi: assert property (
    state_q == ST_M_HI_WAIT |-> byte_select_lsb && !sys_rd_n) // [R05]
    else $error("high byte select or read missing");
  a_slave_strobe_on: assert property (
    state_q == ST_SL_STROBE |-> !data_strobe_n_out && !data_strobe_oe_n) // [R04]
    else $error("slave strobe not driven");
  a_dir_stable: assert property (
    state_q == ST_SL_STROBE && $past(state_q) == ST_SL_STROBE |-> $stable(rw_out)) // [R07]
    else $error("direction changed inside transfer");
  a_latch_quiet: assert property (
    state_q == ST_SL_LATCH |-> data_strobe_n_out && ctrl_data_oe_n) // [R14]
    else $error("controller strobed on latch-only write");
  a_latch_pulse: assert property (
    latch_clock |=> !latch_clock) // [R10]
    else $error("latch clock longer than one cycle");
  a_hold_span: assert property (
    state_q == ST_M_LO_ISSUE |-> ctrl_hold ##1 ctrl_hold) // [R06]
    else $error("hold dropped during word transfer");
  a_a0_master_only: assert property (
    state_q == ST_SL_STROBE |-> byte_select_oe_n) // [R17]
    else $error("byte select driven as slave");

  c_master_word: cover property (state_q == ST_M_HI_WAIT && memory_ack);
  c_slave_latch: cover property (state_q == ST_SL_LATCH ##[1:20] state_q == ST_SL_STROBE);
  c_slave_read: cover property (state_q == ST_SL_STROBE && !cpu_rd_n);
  c_fifo_full: cover property (!fifo_in_ready);
endmodule
`default_nettype wire

// ---- inc/adapter_map.svh ----
// constants for the byte-to-word bus adapter
// Notes on behaviour
// [R01] start only after memory acknowledge goes inactive
// [R02] no sequence while controller direction is write
// [R03] master strobes become byte-wide read strobes
// [R04] processor strobes drive controller slave strobes
// [R05] master read drives byte select and read
// [R06] hold stalls controller during both byte halves
// [R07] controller strobe and direction stable whole cycle
// [R08] grant, request, select, command steer sequencer
// [R09] hold equals one state bit, four states
// [R10] one latch clock strobe, enables always active
// [R11] controller receive enable sets transceiver direction
// [R12] port enable, transceiver direction: dedicated outputs
// [R13] first write latches, second strobes full word
// [R14] no controller strobe on latch-only write
// [R15] peripheral select: reads, unlatched write only; the adapter has no peripheral select output
// [R16] adapter select on every slave byte access
// [R17] byte select driven only as master
// [R18] processor writes latched byte first
// [R19] reset gives idle, strobes inactive, hold off
`ifndef ADAPTER_MAP_SVH
`define ADAPTER_MAP_SVH
`define BYTE_W 8
`define WORD_W 16
`define FIFO_DEPTH 8
`define HOLD_BIT 2
`define LATCHED_A0 1'b1
`define STROBE_IDLE 1'b1
`define DIR_READ 1'b1
`endif

// ---- inc/adapter_pkg.sv ----
// types for the byte-to-word bus adapter
package adapter_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SL_LATCH = 3'b001,
    ST_SL_STROBE = 3'b010,
    ST_M_DONE = 3'b011,
    ST_M_LO_ISSUE = 3'b100,
    ST_M_LO_WAIT = 3'b101,
    ST_M_HI_ISSUE = 3'b110,
    ST_M_HI_WAIT = 3'b111
  } state_t;
endpackage

// ---- core/word_fifo.sv ----
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module word_fifo #(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned DEPTH = 8
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] count_q;
  logic push;
  logic pop;

  assign in_ready = (count_q != (AW+1)'(DEPTH));
  assign out_valid = (count_q != '0);
  assign out_data = mem_q[rd_q];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    bump = (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
  endfunction

  always_ff @(posedge clock) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      wr_q <= '0;
      rd_q <= '0;
      count_q <= '0;
    end else begin
      if (push) begin
        wr_q <= bump(wr_q);
      end
      if (pop) begin
        rd_q <= bump(rd_q);
      end
      if (push && !pop) begin
        count_q <= count_q + 1'b1;
      end else if (pop && !push) begin
        count_q <= count_q - 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ---- tb/mem_model.sv ----
// memory partner answering the adapter's byte read strobes
`timescale 1ns/1ps
`default_nettype none
module mem_model (
  input wire logic clock,
  input wire logic rd_n,
  input wire logic sel_hi,
  input wire logic stuck,
  input wire logic [3:0] lag,
  input wire logic [15:0] word,
  output logic ack,
  output logic [7:0] data
);
  logic [3:0] cnt;
  logic [7:0] last;
  initial begin
    ack = 1'b0;
    cnt = 4'h0;
    last = 8'h00;
  end
  // ack after lag cycles of read strobe, drops once the strobe rises
  always @(posedge clock) begin
    cnt <= #1 rd_n ? 4'h0 : cnt + 4'h1;
    ack <= #1 stuck | (!rd_n & (cnt >= lag));
    last <= #1 rd_n ? last : data;
  end
  // released bus shows the inverse of the last byte
  assign data = rd_n ? ~last : (sel_hi ? word[15:8] : word[7:0]);
endmodule
`default_nettype wire

// ---- tb/byte_to_word_bus_adapter_tb.sv ----
// self-checking bench for the byte-to-word bus adapter
`timescale 1ns/1ps
`default_nettype none
module byte_to_word_bus_adapter_tb;
  logic clock, resetn, astb_n, dstb_n, rw_in, req_n, gin_n, gout_n, cmd, mack, cs_n;
  logic rd_n, wr_n, sa0, rbe_n, wrdy, stb_o, stb_oe, rw_o, rw_oe, sd_oe, srd_n, bsel;
  logic bsel_oe, hold, cd_oe, xcvr, poe_n, lclk, wval, stuck;
  logic [7:0] sdin, sd_out, cbyte, mbyte;
  logic [15:0] cdin, cd_out, wdata, mword;
  logic [3:0] lag;
  int err_count, cmp_count, cyc;

  assign sdin = req_n ? cbyte : mbyte;

  byte_to_word_bus_adapter dut (.clock(clock), .resetn(resetn), .address_strobe_n(astb_n),
    .data_strobe_n_in(dstb_n), .data_strobe_n_out(stb_o), .data_strobe_oe_n(stb_oe),
    .rw_in(rw_in), .rw_out(rw_o), .rw_oe_n(rw_oe), .bus_request_n(req_n),
    .grant_chain_in_n(gin_n), .grant_chain_out_n(gout_n), .command_data(cmd),
    .memory_ack(mack), .chip_select_n(cs_n), .cpu_rd_n(rd_n), .cpu_wr_n(wr_n),
    .sys_a0(sa0), .sys_data_in(sdin), .sys_data_out(sd_out), .sys_data_oe_n(sd_oe),
    .sys_rd_n(srd_n), .byte_select_lsb(bsel), .byte_select_oe_n(bsel_oe),
    .ctrl_hold(hold), .ctrl_data_in(cdin), .ctrl_data_out(cd_out), .ctrl_data_oe_n(cd_oe),
    .receive_buffer_enable_n(rbe_n), .xcvr_to_ctrl(xcvr), .port_output_enable_n(poe_n),
    .latch_clock(lclk), .word_data(wdata), .word_valid(wval), .word_ready(wrdy));

  mem_model mem (.clock(clock), .rd_n(srd_n), .sel_hi(bsel), .stuck(stuck), .lag(lag),
    .word(mword), .ack(mack), .data(mbyte));

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  task automatic step(int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic chk(string nm, logic [15:0] got, logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      err_count++;
    end
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  always @(posedge clock) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      give_verdict();
    end
  end

  task automatic mread(logic [15:0] w, logic [3:0] l, logic rw, logic take);
    int i;
    mword = w;
    lag = l;
    req_n = 0; gin_n = 0; gout_n = 1; rw_in = rw; rbe_n = 0;
    astb_n = 0;
    dstb_n = 0;
    i = 0;
    while (hold !== 1'b1 && i < 20) begin step(1); i++; end
    chk("hold", hold, take);
    chk("rd_n", srd_n, !take);
    if (take) begin
      chk("bsel", bsel, 0);
      chk("bsel_oe", bsel_oe, 0);
      while (hold === 1'b1 && i < 60) begin step(1); i++; end
    end
    astb_n = 1;
    dstb_n = 1;
    rbe_n = 1;
    step(2);
  endtask

  task automatic t_fifo();
    int i;
    wrdy = 0;
    // the output register holds one word beyond the eight queued ones
    for (int k = 0; k < 9; k++) mread(16'h1100 + 16'(k) * 16'h0111, 4'(k % 4), 1, 1);
    mread(16'hdead, 0, 1, 0);
    wrdy = 1;
    for (int k = 0; k < 9; k++) begin
      i = 0;
      while (wval !== 1'b1 && i < 10) begin step(1); i++; end
      chk("word", wdata, 16'h1100 + 16'(k) * 16'h0111);
      step(1);
    end
    chk("empty", wval, 0);
  endtask

  task automatic swrite(logic [7:0] hi, logic [7:0] lo, logic c);
    req_n = 1; cs_n = 0; cmd = c; rbe_n = 0;
    if (!c) begin
      sa0 = 1; cbyte = hi; wr_n = 0;
      step(1);
      chk("lclk", lclk, 1);
      chk("stb_latch", stb_o, 1);
      step(1);
      chk("lclk_pulse", lclk, 0);
      wr_n = 1;
      step(1);
      chk("stb_gap", stb_o, 1);
    end
    sa0 = 0;
    cbyte = lo;
    wr_n = 0;
    step(2);
    chk("stb_w", stb_o, 0);
    chk("stb_oe", stb_oe, 0);
    chk("rw_w", rw_o, 0);
    chk("word_w", cd_out, c ? {8'h00, lo} : {hi, lo});
    chk("cd_oe", cd_oe, 0);
    chk("rw_oe", rw_oe, 0);
    chk("xcvr", xcvr, 1);
    wr_n = 1;
    cs_n = 1;
    rbe_n = 1;
    step(2);
    chk("stb_end", stb_o, 1);
  endtask

  task automatic sread();
    req_n = 1; cs_n = 0; cmd = 0; cdin = 16'h5a3c;
    for (int b = 0; b < 2; b++) begin
      sa0 = b[0];
      rd_n = 0;
      step(2);
      chk("stb_r", stb_o, 0);
      chk("rw_r", rw_o, 1);
      chk("sd_oe", sd_oe, 0);
      chk("sd_out", sd_out, b[0] ? 16'h5a : 16'h3c);
      chk("poe", poe_n, !b[0]);
      chk("bsel_oe_s", bsel_oe, 1);
      rd_n = 1;
      step(2);
    end
    cs_n = 1;
  endtask

  initial begin
    resetn = 0; astb_n = 1; dstb_n = 1; rw_in = 1; req_n = 1; gin_n = 1; gout_n = 1;
    cmd = 0; cs_n = 1; rd_n = 1; wr_n = 1; sa0 = 0; rbe_n = 1; wrdy = 1; stuck = 0;
    cbyte = 8'h00; cdin = 16'h0000; mword = 16'h0000; lag = 4'h0;
    err_count = 0; cmp_count = 0; cyc = 0;
    step(4);
    chk("rst_hold", hold, 0);
    chk("rst_rd", srd_n, 1);
    chk("rst_stb", stb_o, 1);
    chk("rst_wval", wval, 0);
    resetn = 1;
    step(1);
    mread(16'hbeef, 0, 1, 1);
    mread(16'h7c21, 5, 1, 1);
    mread(16'h0f0f, 0, 0, 0);
    stuck = 1;
    // let the acknowledge rise before the request is offered
    step(2);
    mread(16'h0f0f, 0, 1, 0);
    stuck = 0;
    step(2);
    $display("master read tests done");
    t_fifo();
    $display("fifo test done");
    swrite(8'hab, 8'hcd, 0);
    swrite(8'h00, 8'h42, 1);
    sread();
    $display("slave tests done");
    give_verdict();
  end
endmodule
`default_nettype wire
